// ==== logic/tfsc_pkg.sv ====
/*
 package for the fire and sequencing configuration bank: register indices,
 field positions, reset values and timing constants.
 assumes a 25 MHz core clock.
*/
package tfsc_pkg;
	localparam int unsigned CLK_HZ = 25000000;
	localparam logic [2:0]  ADDR_FIRE_CFG = 3'h5;
	localparam logic [2:0]  ADDR_ANA_CFG  = 3'h6;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	// fire_output_config fields
	localparam int OUT_SEL_HI = 31;
	localparam int OUT_SEL_LO = 29;
	localparam int START_NOISE_BIT = 28;
	localparam int PHASE_NOISE_DIS_BIT = 27;
	localparam int REPEAT_HI = 26;
	localparam int REPEAT_LO = 24;
	localparam int PHASE_MASK_HI = 23;
	localparam int PHASE_MASK_LO = 8;
	// analog_timing_resolution_config fields
	localparam int ANA_EN_BIT = 31;
	localparam int TEMP_INV_BIT = 30;
	localparam int OFFS_HI = 28;
	localparam int OFFS_LO = 25;
	localparam int CHARGE_HI = 23;
	localparam int CHARGE_LO = 22;
	localparam int EE_IRQ_BIT = 21;
	localparam int SETTLE_HI_BIT = 20;
	localparam int CYC_TEMP_HI = 19;
	localparam int CYC_TEMP_LO = 18;
	localparam int CYC_TOF_HI = 17;
	localparam int CYC_TOF_LO = 16;
	localparam int MAINS_BIT = 15;
	localparam int IDLE_LVL_BIT = 14;
	localparam int QUAD_BIT = 13;
	localparam int DOUBLE_BIT = 12;
	localparam int PORT_ORDER_BIT = 11;
	localparam int PCOUNT_HI = 10;
	localparam int PCOUNT_LO = 8;
	localparam logic [6:0]  PHASE_MASK_MAX_COUNT = 7'h0f;
	// base periods in microseconds, half periods counted
	localparam int unsigned BASE50_US = 20000;
	localparam int unsigned BASE60_US = 16667;
	localparam int unsigned HALF50_CYC = (BASE50_US / 2) * (CLK_HZ / 1000000);
	localparam int unsigned HALF60_CYC = (BASE60_US / 2) * (CLK_HZ / 1000000);
	// rc charge times in microseconds
	localparam int unsigned CHG0_US = 90;
	localparam int unsigned CHG1_US = 120;
	localparam int unsigned CHG2_US = 150;
	localparam int unsigned CHG3_US = 300;
	localparam int unsigned CYC_PER_US = CLK_HZ / 1000000;
	// oscillator settle times in microseconds
	localparam int unsigned SETTLE2_US = 480;
	localparam int unsigned SETTLE3_US = 1460;
	localparam int unsigned SETTLE4_US = 2440;
	localparam int unsigned SETTLE5_US = 5140;
	// time bins in picoseconds
	localparam logic [6:0]  BIN_NORMAL_PS = 7'h5a;
	localparam logic [6:0]  BIN_DOUBLE_PS = 7'h2d;
	localparam logic [6:0]  BIN_QUAD_PS   = 7'h16;
	typedef enum logic [1:0] {
		TFSC_IDLE = 2'b00,
		TFSC_WAIT = 2'b01,
		TFSC_DONE = 2'b10
	} tfsc_state_e;
endpackage

// ==== logic/tfsc_interval_timer.sv ====
/*
 interval timer: waits a number of half base periods after a start pulse.
 assumes start only while idle; half-period length chosen by mains select.
*/
`timescale 1ns/1ns
module tfsc_interval_timer (
	input  wire logic       core_clk_i,
	input  wire logic       resetn_i,
	input  wire logic       start_i,
	input  wire logic       mains_sel_i,
	input  wire logic [1:0] cycle_code_i,
	output logic            fire_o
);
	import tfsc_pkg::*;
	logic [18:0] half_cnt_reg;
	logic [18:0] half_cnt_next;
	logic [2:0]  halves_reg;
	logic [2:0]  halves_next;
	logic        busy_reg;
	logic        busy_next;
	logic        fire_next;
	logic [18:0] half_len;

	always_comb begin
		half_len = mains_sel_i ? 19'(HALF60_CYC - 1) : 19'(HALF50_CYC - 1);
		half_cnt_next = half_cnt_reg;
		halves_next = halves_reg;
		busy_next = busy_reg;
		fire_next = 1'b0;
		if (!busy_reg) begin
			if (start_i) begin
				busy_next = 1'b1;
				half_cnt_next = half_len;
				halves_next = 3'(cycle_code_i) + 3'h2;
			end
		end else if (half_cnt_reg != 19'h0_0000) begin
			half_cnt_next = half_cnt_reg - 19'h0_0001;
		end else if (halves_reg == 3'h1) begin
			busy_next = 1'b0;
			fire_next = 1'b1;
		end else begin
			halves_next = halves_reg - 3'h1;
			half_cnt_next = half_len;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			half_cnt_reg <= 19'h0_0000;
			halves_reg <= 3'h0;
			busy_reg <= 1'b0;
			fire_o <= 1'b0;
		end else begin
			half_cnt_reg <= half_cnt_next;
			halves_reg <= halves_next;
			busy_reg <= busy_next;
			fire_o <= fire_next;
		end
	end
endmodule

// ==== logic/tfsc_config_bank.sv ====
/*
 fire and sequencing configuration bank with fire pulse generator,
 analog front-end control, timing and resolution outputs.
 assumes a host write port (address, data, strobe) and a fire period enable.
*/
// How it works
// - top output bit inverts downstream; middle enables upstream; low enables downstream.
// - start noise enable bit switches noise unit on for start channel.
// - phase noise disable bit one turns off phase noise unit.
// - whole pulse sequence repeats zero to seven extra times.
// - each of first fifteen pulses inverted when its mask bit set.
// - analog enable makes stops analog, muxed, powered only during measurement.
// - temperature invert bit inverts the temperature sense input.
// - comparator offset is two's complement, minus eight to plus seven millivolts.
// - charge timer code gives 90, 120, 150 or 300 microseconds.
// - fourth interrupt enable adds end-of-eeprom source; sources ORed.
// - settle code from upper bit plus two lower bits selects delay.
// - second temperature measurement delayed 1 to 2.5 base periods.
// - second flight measurement delayed 1 to 2.5 base periods.
// - base period 20 ms or 16.67 ms by mains select.
// - inactive fire driver idles high impedance or low.
// - quadruple resolution gives 22 ps bins, mode two only.
// - double resolution gives 45 ps; mode one then only first stop.
// - temperature ports measured ascending or descending by order bit.
// - seven-bit pulse count from upper three plus lower four bits.
// - phase mask ignored when pulse count exceeds fifteen.
`timescale 1ns/1ns
module tfsc_config_bank (
	input  wire logic       core_clk_i,
	input  wire logic       resetn_i,
	input  wire logic       wr_en_i,
	input  wire logic [2:0] wr_addr_i,
	input  wire logic [31:0] wr_data_i,
	input  wire logic [3:0] pulse_count_low_i,
	input  wire logic [1:0] settle_low_i,
	input  wire logic [2:0] int_enable_low_i,
	input  wire logic [2:0] int_source_low_i,
	input  wire logic       eeprom_done_i,
	input  wire logic       fire_period_en_i,
	input  wire logic       fire_start_i,
	input  wire logic       meas_active_i,
	input  wire logic       measure_mode2_i,
	input  wire logic       tof_first_done_i,
	input  wire logic       temp_first_done_i,
	input  wire logic       temperature_sense_input_i,
	output logic            fire_up_o,
	output logic            fire_up_oen_n_o,
	output logic            fire_down_o,
	output logic            fire_down_oen_n_o,
	output logic            fire_busy_o,
	output logic            start_channel_noise_enable_o,
	output logic            phase_noise_enable_o,
	output logic            analog_stop_sel_o,
	output logic            analog_power_o,
	output logic            temp_sense_o,
	output logic signed [3:0] comparator_offset_trim_o,
	output logic            rc_charge_done_o,
	output logic [2:0]      oscillator_settle_select_o,
	output logic [16:0]     settle_cycles_o,
	output logic            second_tof_trigger_o,
	output logic            second_temp_trigger_o,
	output logic [6:0]      bin_ps_o,
	output logic            stop_input_two_enable_o,
	output logic            temp_port_order_o,
	output logic            irq_o
);
	import tfsc_pkg::*;

	// longest settle time needs seventeen bits of core cycles
	function automatic logic [16:0] us_to_cyc(input int unsigned us);
		us_to_cyc = 17'(us * CYC_PER_US);
	endfunction

	logic [31:0] fire_cfg_reg;
	logic [31:0] fire_cfg_next;
	logic [31:0] ana_cfg_reg;
	logic [31:0] ana_cfg_next;

	always_comb begin
		fire_cfg_next = fire_cfg_reg;
		ana_cfg_next = ana_cfg_reg;
		if (wr_en_i && wr_addr_i == ADDR_FIRE_CFG)
			fire_cfg_next = wr_data_i;
		if (wr_en_i && wr_addr_i == ADDR_ANA_CFG)
			ana_cfg_next = wr_data_i;
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			fire_cfg_reg <= RESET_WORD;
			ana_cfg_reg <= RESET_WORD;
		end else begin
			fire_cfg_reg <= fire_cfg_next;
			ana_cfg_reg <= ana_cfg_next;
		end
	end

	// field views
	logic [2:0]  out_sel;
	logic [2:0]  repeat_cnt;
	logic [15:0] phase_mask;
	logic [6:0]  pulse_total;
	logic        idle_low;
	assign out_sel = fire_cfg_reg[OUT_SEL_HI:OUT_SEL_LO];
	assign repeat_cnt = fire_cfg_reg[REPEAT_HI:REPEAT_LO];
	assign phase_mask = fire_cfg_reg[PHASE_MASK_HI:PHASE_MASK_LO];
	assign pulse_total = {ana_cfg_reg[PCOUNT_HI:PCOUNT_LO], pulse_count_low_i};
	assign idle_low = ana_cfg_reg[IDLE_LVL_BIT];

	// fire pulse generator: each pulse is a high then low period enable
	logic [6:0]  pulse_idx_reg;
	logic [6:0]  pulse_idx_next;
	logic [2:0]  rep_left_reg;
	logic [2:0]  rep_left_next;
	logic        phase_reg;
	logic        phase_next;
	logic        running_reg;
	logic        running_next;
	logic        wave;
	logic        up_lvl;
	logic        dn_lvl;
	logic        fire_up_next;
	logic        fire_up_oen_n_next;
	logic        fire_down_next;
	logic        fire_down_oen_n_next;

	always_comb begin
		pulse_idx_next = pulse_idx_reg;
		rep_left_next = rep_left_reg;
		phase_next = phase_reg;
		running_next = running_reg;
		if (!running_reg) begin
			if (fire_start_i && pulse_total != 7'h00) begin
				running_next = 1'b1;
				pulse_idx_next = 7'h00;
				phase_next = 1'b0;
				rep_left_next = repeat_cnt;
			end
		end else if (fire_period_en_i) begin
			phase_next = ~phase_reg;
			if (phase_reg) begin
				if (pulse_idx_reg == pulse_total - 7'h01) begin
					pulse_idx_next = 7'h00;
					if (rep_left_reg == 3'h0)
						running_next = 1'b0;
					else
						rep_left_next = rep_left_reg - 3'h1;
				end else begin
					pulse_idx_next = pulse_idx_reg + 7'h01;
				end
			end
		end
		wave = running_reg & ~phase_reg;
		if (pulse_total <= PHASE_MASK_MAX_COUNT && running_reg &&
				phase_mask[pulse_idx_reg[3:0]])
			wave = phase_reg;
		up_lvl = wave;
		dn_lvl = out_sel[2] ? ~wave : wave;
		// enabled outputs drive; inactive one is z or low
		fire_up_next = out_sel[1] & running_reg & up_lvl;
		fire_up_oen_n_next = ~((out_sel[1] & running_reg) | idle_low);
		fire_down_next = out_sel[0] & running_reg & dn_lvl;
		fire_down_oen_n_next = ~((out_sel[0] & running_reg) | idle_low);
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			pulse_idx_reg <= 7'h00;
			rep_left_reg <= 3'h0;
			phase_reg <= 1'b0;
			running_reg <= 1'b0;
			fire_up_o <= 1'b0;
			fire_up_oen_n_o <= 1'b1;
			fire_down_o <= 1'b0;
			fire_down_oen_n_o <= 1'b1;
			fire_busy_o <= 1'b0;
		end else begin
			pulse_idx_reg <= pulse_idx_next;
			rep_left_reg <= rep_left_next;
			phase_reg <= phase_next;
			running_reg <= running_next;
			fire_busy_o <= running_next;
			fire_up_o <= fire_up_next;
			fire_up_oen_n_o <= fire_up_oen_n_next;
			fire_down_o <= fire_down_next;
			fire_down_oen_n_o <= fire_down_oen_n_next;
		end
	end

	// rc charge timer, started when a measurement begins with analog on
	logic [13:0] chg_cnt_reg;
	logic [13:0] chg_cnt_next;
	logic        meas_d_reg;
	logic        chg_done_next;
	logic [13:0] chg_len;
	logic [16:0] settle_len;
	// next values of the registered control outputs
	logic              noise_en_next;
	logic              phase_noise_en_next;
	logic              stop_sel_next;
	logic              power_next;
	logic              temp_sense_next;
	logic signed [3:0] offset_next;
	logic [2:0]        settle_sel_next;
	logic [6:0]        bin_next;
	logic              stop_two_next;
	logic              port_order_next;
	logic              irq_next;

	always_comb begin
		case (ana_cfg_reg[CHARGE_HI:CHARGE_LO])
			2'h0: chg_len = 14'(us_to_cyc(CHG0_US));
			2'h1: chg_len = 14'(us_to_cyc(CHG1_US));
			2'h2: chg_len = 14'(us_to_cyc(CHG2_US));
			default: chg_len = 14'(us_to_cyc(CHG3_US));
		endcase
		settle_sel_next = {ana_cfg_reg[SETTLE_HI_BIT], settle_low_i};
		// cycle count follows the select in the same cycle
		case (settle_sel_next)
			3'h0: settle_len = 17'h0_0000;
			3'h1: settle_len = 17'h0_0000;
			3'h2: settle_len = us_to_cyc(SETTLE2_US);
			3'h3: settle_len = us_to_cyc(SETTLE3_US);
			3'h4: settle_len = us_to_cyc(SETTLE4_US);
			default: settle_len = us_to_cyc(SETTLE5_US);
		endcase
		chg_cnt_next = chg_cnt_reg;
		chg_done_next = rc_charge_done_o;
		if (!ana_cfg_reg[ANA_EN_BIT] || !meas_active_i) begin
			chg_cnt_next = 14'h0000;
			chg_done_next = 1'b0;
		end else if (!meas_d_reg) begin
			chg_cnt_next = chg_len;
		end else if (chg_cnt_reg != 14'h0000) begin
			chg_cnt_next = chg_cnt_reg - 14'h0001;
		end else begin
			chg_done_next = 1'b1;
		end
		noise_en_next = fire_cfg_reg[START_NOISE_BIT];
		phase_noise_en_next = ~fire_cfg_reg[PHASE_NOISE_DIS_BIT];
		stop_sel_next = ana_cfg_reg[ANA_EN_BIT];
		power_next = ana_cfg_reg[ANA_EN_BIT] & meas_active_i;
		temp_sense_next = temperature_sense_input_i ^ ana_cfg_reg[TEMP_INV_BIT];
		offset_next = signed'(ana_cfg_reg[OFFS_HI:OFFS_LO]);
		// quadruple only counts in mode two; otherwise double if its bit is set, else normal
		bin_next = BIN_NORMAL_PS;
		if (ana_cfg_reg[QUAD_BIT] && measure_mode2_i)
			bin_next = BIN_QUAD_PS;
		else if (ana_cfg_reg[DOUBLE_BIT])
			bin_next = BIN_DOUBLE_PS;
		stop_two_next = measure_mode2_i | ~ana_cfg_reg[DOUBLE_BIT];
		port_order_next = ana_cfg_reg[PORT_ORDER_BIT];
		irq_next = |(int_enable_low_i & int_source_low_i) |
			(ana_cfg_reg[EE_IRQ_BIT] & eeprom_done_i);
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			chg_cnt_reg <= 14'h0000;
			meas_d_reg <= 1'b0;
			rc_charge_done_o <= 1'b0;
			start_channel_noise_enable_o <= 1'b0;
			phase_noise_enable_o <= 1'b0;
			analog_stop_sel_o <= 1'b0;
			analog_power_o <= 1'b0;
			temp_sense_o <= 1'b0;
			comparator_offset_trim_o <= 4'h0;
			oscillator_settle_select_o <= 3'h0;
			settle_cycles_o <= 17'h0_0000;
			bin_ps_o <= BIN_NORMAL_PS;
			stop_input_two_enable_o <= 1'b0;
			temp_port_order_o <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			chg_cnt_reg <= chg_cnt_next;
			meas_d_reg <= meas_active_i;
			rc_charge_done_o <= chg_done_next;
			start_channel_noise_enable_o <= noise_en_next;
			phase_noise_enable_o <= phase_noise_en_next;
			analog_stop_sel_o <= stop_sel_next;
			analog_power_o <= power_next;
			temp_sense_o <= temp_sense_next;
			comparator_offset_trim_o <= offset_next;
			oscillator_settle_select_o <= settle_sel_next;
			settle_cycles_o <= settle_len;
			bin_ps_o <= bin_next;
			stop_input_two_enable_o <= stop_two_next;
			temp_port_order_o <= port_order_next;
			irq_o <= irq_next;
		end
	end

	tfsc_interval_timer u_tof_timer (
		.core_clk_i   (core_clk_i),
		.resetn_i     (resetn_i),
		.start_i      (tof_first_done_i),
		.mains_sel_i  (ana_cfg_reg[MAINS_BIT]),
		.cycle_code_i (ana_cfg_reg[CYC_TOF_HI:CYC_TOF_LO]),
		.fire_o       (second_tof_trigger_o)
	);

	tfsc_interval_timer u_temp_timer (
		.core_clk_i   (core_clk_i),
		.resetn_i     (resetn_i),
		.start_i      (temp_first_done_i),
		.mains_sel_i  (ana_cfg_reg[MAINS_BIT]),
		.cycle_code_i (ana_cfg_reg[CYC_TEMP_HI:CYC_TEMP_LO]),
		.fire_o       (second_temp_trigger_o)
	);
endmodule

// ==== tb/tfsc_config_props.sv ====
/*
 port relations of the fire and sequencing configuration bank.
 assumes the package is compiled first; bound to the bank below.
*/
`timescale 1ns/1ns
module tfsc_config_props
	import tfsc_pkg::*;
(
	input  wire logic              core_clk_i,
	input  wire logic              resetn_i,
	input  wire logic              wr_en_i,
	input  wire logic [2:0]        wr_addr_i,
	input  wire logic [31:0]       wr_data_i,
	input  wire logic [2:0]        int_enable_low_i,
	input  wire logic [2:0]        int_source_low_i,
	input  wire logic              eeprom_done_i,
	input  wire logic              fire_up_o,
	input  wire logic              fire_up_oen_n_o,
	input  wire logic              start_channel_noise_enable_o,
	input  wire logic              phase_noise_enable_o,
	input  wire logic              analog_stop_sel_o,
	input  wire logic              analog_power_o,
	input  wire logic signed [3:0] comparator_offset_trim_o,
	input  wire logic              second_tof_trigger_o,
	input  wire logic [6:0]        bin_ps_o,
	input  wire logic              temp_port_order_o,
	input  wire logic              irq_o
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!resetn_i);
	wire w5 = wr_en_i && wr_addr_i == ADDR_FIRE_CFG;
	wire w6 = wr_en_i && wr_addr_i == ADDR_ANA_CFG;
	wire src = |(int_enable_low_i & int_source_low_i);

	a_noise_write: assert property (w5 |-> ##2
		start_channel_noise_enable_o == $past(wr_data_i[START_NOISE_BIT], 2))
		else $error("start noise enable does not follow write");
	a_phase_noise_write: assert property (w5 |-> ##2
		phase_noise_enable_o != $past(wr_data_i[PHASE_NOISE_DIS_BIT], 2))
		else $error("phase noise enable does not follow write");
	a_offset_write: assert property (w6 |-> ##2
		comparator_offset_trim_o == $signed($past(wr_data_i[OFFS_HI:OFFS_LO], 2)))
		else $error("comparator offset does not follow write");
	a_order_write: assert property (w6 |-> ##2
		temp_port_order_o == $past(wr_data_i[PORT_ORDER_BIT], 2))
		else $error("port order does not follow write");
	a_bin_normal: assert property (w6 && !wr_data_i[QUAD_BIT] && !wr_data_i[DOUBLE_BIT]
		|-> ##2 bin_ps_o == BIN_NORMAL_PS)
		else $error("time bin not normal");
	a_power_analog: assert property (analog_power_o |-> analog_stop_sel_o)
		else $error("analog powered while disabled");
	a_irq_sources: assert property (src |=> irq_o)
		else $error("irq missing for enabled source");
	a_irq_quiet: assert property (!eeprom_done_i && !src |=> !irq_o)
		else $error("irq without source");
	a_up_driven: assert property (fire_up_o |-> !fire_up_oen_n_o)
		else $error("upstream high while released");
	a_trigger_pulse: assert property (second_tof_trigger_o |=> !second_tof_trigger_o)
		else $error("trigger longer than one cycle");
endmodule

bind tfsc_config_bank tfsc_config_props tfsc_config_props_inst (.*);

// ==== tb/tfsc_transducer_model.sv ====
/*
 transducer pair on the fire pins: counts driven rising edges.
 assumes low-active output enables; a released pin leaves it at rest.
*/
`timescale 1ns/1ns
module tfsc_transducer_model (
	input  wire logic core_clk_i,
	input  wire logic up_i,
	input  wire logic up_oen_n_i,
	input  wire logic down_i,
	input  wire logic down_oen_n_i,
	output int        up_rises_o,
	output int        down_rises_o
);
	logic up_prev = 1'b0;
	logic down_prev = 1'b0;
	int   nu = 0;
	int   nd = 0;
	assign up_rises_o = nu;
	assign down_rises_o = nd;
	always @(posedge core_clk_i) begin
		if (!up_oen_n_i && up_i && !up_prev) nu <= nu + 1;
		if (!down_oen_n_i && down_i && !down_prev) nd <= nd + 1;
		up_prev <= !up_oen_n_i && up_i;
		down_prev <= !down_oen_n_i && down_i;
	end
endmodule

// ==== tb/test_tof_fire_and_sequencing_config.sv ====
/*
 self-checking bench of the configuration bank and fire generator.
 assumes the checker is bound and the transducer model compiled.
*/
`timescale 1ns/1ns
module test_tof_fire_and_sequencing_config;
	import tfsc_pkg::*;
	logic core_clk_i = 0, resetn_i = 0, wr_en_i = 0, eeprom_done_i = 0, fire_period_en_i = 0;
	logic fire_start_i = 0, meas_active_i = 0, measure_mode2_i = 0, temperature_sense_input_i = 0;
	logic tof_first_done_i = 0, temp_first_done_i = 0;
	logic [2:0] wr_addr_i = 0, int_enable_low_i = 0, int_source_low_i = 0;
	logic [31:0] wr_data_i = 0;
	logic [3:0] pulse_count_low_i = 0;
	logic [1:0] settle_low_i = 0;
	logic fire_up_o, fire_up_oen_n_o, fire_down_o, fire_down_oen_n_o, fire_busy_o, analog_power_o;
	logic start_channel_noise_enable_o, phase_noise_enable_o, analog_stop_sel_o, temp_sense_o;
	logic rc_charge_done_o, second_tof_trigger_o, second_temp_trigger_o, irq_o;
	logic stop_input_two_enable_o, temp_port_order_o;
	logic signed [3:0] comparator_offset_trim_o;
	logic [2:0] oscillator_settle_select_o;
	logic [16:0] settle_cycles_o;
	int n_trig = 0;
	logic [6:0] bin_ps_o;
	int up_r, dn_r, n_fail = 0, checked = 0, seed = 32'hb058, k, cnt, rep, n, bu, bd;
	logic [31:0] w5, w6, r;
	logic [2:0] sel;
	logic [15:0] mask;
	logic [1:0] pc = 0;
	logic idle;
	logic [2:0] tbl [6] = '{3'b110, 3'b101, 3'b111, 3'b010, 3'b100, 3'b001};

	tfsc_config_bank tfsc_config_bank_inst (.*);
	tfsc_transducer_model tfsc_transducer_model_inst (.core_clk_i(core_clk_i),
		.up_i(fire_up_o), .up_oen_n_i(fire_up_oen_n_o), .down_i(fire_down_o),
		.down_oen_n_i(fire_down_oen_n_o), .up_rises_o(up_r), .down_rises_o(dn_r));

	always #20 core_clk_i = ~core_clk_i;
	always @(negedge core_clk_i) begin
		pc <= pc + 2'h1;
		fire_period_en_i <= (pc == 2'h0);
	end
	// second-measurement triggers seen during the run
	always @(negedge core_clk_i) n_trig += second_tof_trigger_o + second_temp_trigger_o;

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [31:0] d);
		@(negedge core_clk_i);
		wr_en_i = 1;
		wr_addr_i = a;
		wr_data_i = d;
	endtask
	// rising edges seen on a pin for a pulse train, each pulse high then low
	function automatic int rises(int c, int m, int rp, bit iv);
		int q[$];
		int s = 0;
		int pv = 0;
		for (int i = 0; i <= rp; i++)
			for (int p = 0; p < c; p++) begin
				q.push_back(iv ^ !(c <= 15 && m[p]));
				q.push_back(iv ^ (c <= 15 && m[p]));
			end
		foreach (q[i]) begin
			s += (q[i] && !pv);
			pv = q[i];
		end
		return s;
	endfunction
	task complete_run;
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	initial begin
		#(40 * 60000);
		n_fail++;
		complete_run;
	end
	initial begin
		repeat (16) @(negedge core_clk_i);
		resetn_i = 1;
		chk(bin_ps_o, BIN_NORMAL_PS);
		chk({fire_up_oen_n_o, fire_down_oen_n_o}, 2'b11);
		for (k = 0; k < 24; k++) begin
			w5 = $random(seed);
			w6 = $random(seed);
			if (w5[31:29] == 3'b011) w5[31] = 1'b1;
			r = $random(seed);
			@(negedge core_clk_i);
			{meas_active_i, measure_mode2_i, temperature_sense_input_i, eeprom_done_i} = r[3:0];
			{int_enable_low_i, int_source_low_i, settle_low_i} = r[15:8];
			wr(ADDR_FIRE_CFG, w5);
			wr(ADDR_ANA_CFG, w6);
			wr(3'h7, ~w6);
			@(negedge core_clk_i) wr_en_i = 0;
			repeat (2) @(negedge core_clk_i);
			chk(start_channel_noise_enable_o, w5[START_NOISE_BIT]);
			chk(phase_noise_enable_o, !w5[PHASE_NOISE_DIS_BIT]);
			chk({analog_stop_sel_o, analog_power_o}, {w6[31], w6[31] & r[3]});
			chk(temp_sense_o, r[1] ^ w6[TEMP_INV_BIT]);
			chk(comparator_offset_trim_o, $signed(w6[OFFS_HI:OFFS_LO]));
			chk(oscillator_settle_select_o, {w6[SETTLE_HI_BIT], r[9:8]});
			sel = {w6[SETTLE_HI_BIT], r[9:8]};
			chk(settle_cycles_o, ((sel < 3'h2) ? 0 : (sel == 3'h2) ? SETTLE2_US : (sel == 3'h3) ?
				SETTLE3_US : (sel == 3'h4) ? SETTLE4_US : SETTLE5_US) * CYC_PER_US);
			chk(bin_ps_o, (r[2] && w6[QUAD_BIT]) ? BIN_QUAD_PS :
				(w6[DOUBLE_BIT] ? BIN_DOUBLE_PS : BIN_NORMAL_PS));
			chk(stop_input_two_enable_o, !(w6[DOUBLE_BIT] && !r[2]));
			chk(temp_port_order_o, w6[PORT_ORDER_BIT]);
			chk(irq_o, |(r[15:13] & r[12:10]) | (w6[EE_IRQ_BIT] & r[0]));
		end
		for (k = 0; k < 8; k++) begin
			r = $random(seed);
			sel = tbl[k % 6];
			cnt = (k == 6) ? 0 : (k == 7) ? 40 : (k == 5) ? 16 : r[3:0] + 1;
			rep = (k == 0) ? 7 : r[5:4];
			mask = r[31:16] & ~16'h0001 & ~(16'h0001 << (cnt - 1));
			idle = r[6];
			bu = up_r;
			bd = dn_r;
			wr(ADDR_FIRE_CFG, {sel, 2'b00, rep[2:0], mask, 8'h00});
			wr(ADDR_ANA_CFG, {17'h0, idle, 3'b000, cnt[6:4], 8'h00});
			@(negedge core_clk_i) wr_en_i = 0;
			pulse_count_low_i = cnt[3:0];
			fire_start_i = 1;
			@(negedge core_clk_i) fire_start_i = 0;
			chk(fire_busy_o, cnt != 0);
			n = 0;
			while ((fire_busy_o === 1'b1 || n < 4) && n < 6000) begin
				@(negedge core_clk_i);
				n++;
			end
			if (n >= 6000) n_fail++;
			repeat (2) @(negedge core_clk_i);
			chk(up_r - bu, sel[1] ? rises(cnt, mask, rep, 0) : 0);
			chk(dn_r - bd, sel[0] ? rises(cnt, mask, rep, sel[2]) : 0);
			if (!sel[1]) chk(fire_up_oen_n_o, !idle);
			if (!sel[0]) chk(fire_down_oen_n_o, !idle);
		end
		// timers must not fire before one base period has passed
		@(negedge core_clk_i) {tof_first_done_i, temp_first_done_i} = 2'b11;
		@(negedge core_clk_i) {tof_first_done_i, temp_first_done_i} = 2'b00;
		// rc charge: done after the coded time, cleared when measuring stops
		for (k = 0; k < 4; k += 3) begin
			meas_active_i = 0;
			wr(ADDR_ANA_CFG, {1'b1, 7'h00, k[1:0], 7'h00, 1'b1, 14'h0000});
			@(negedge core_clk_i) wr_en_i = 0;
			meas_active_i = 1;
			n = 0;
			while (rc_charge_done_o !== 1'b1 && n < 8000) begin
				@(negedge core_clk_i);
				n++;
			end
			chk(analog_power_o, 1'b1);
			// counter load and output register add two cycles
			chk(n, ((k == 0) ? CHG0_US : CHG3_US) * CYC_PER_US + 2);
			meas_active_i = 0;
			repeat (2) @(negedge core_clk_i);
			chk({rc_charge_done_o, analog_power_o}, 2'b00);
		end
		chk(n_trig, 0);
		complete_run;
	end
endmodule
